/* verilog/flash_protection_cfg.svh */
// Offsets, field positions, reset values and timing for flash protection
`ifndef FLASH_PROTECTION_CFG_SVH
`define FLASH_PROTECTION_CFG_SVH

// Register byte offsets within the APB window
`define OFF_TARGET_ADDRESS 12'h000
`define OFF_WRITE_DATA 12'h004
`define OFF_FLASH_CONTROL 12'h008
`define OFF_RAW_IRQ_STATUS 12'h00C
`define OFF_IRQ_MASK 12'h010
`define OFF_MASKED_STATUS_CLEAR 12'h014
`define OFF_READ_ENABLE_BITS 12'h130
`define OFF_PROGRAM_ENABLE_BITS 12'h134
`define OFF_USEC_RELOAD 12'h140
`define OFF_ALIAS_ADDR 12'h200
`define OFF_ALIAS_DATA 12'h204
`define OFF_FETCH_ADDR 12'h208
`define OFF_FETCH_DATA 12'h20C
`define OFF_DEBUG_STATUS 12'h210

// Flash control bits
`define CTL_WRITE 0
`define CTL_ERASE 1
`define CTL_MERASE 2
`define CTL_COMMIT 3
`define CTL_KEY_LSB 16
`define CTL_KEY 16'hA442

// Interrupt status bits
`define IRQ_ACCESS 0
`define IRQ_PROGRAM 1

// Commit address selecting the debug field plus read enables
`define COMMIT_DEBUG_ADDR 32'h0000_0900

// Debug field in read-enable register
`define DBG_LSB 30
`define DBG_ENABLED 2'h2

// Reset values
`define READ_ENABLE_RESET 32'h8000_FFFF
`define PROGRAM_ENABLE_RESET 32'h0000_FFFF
`define USEC_RELOAD_RESET 8'h31

// Flash timing, microseconds
`define PROGRAM_TIME_US 20
`define ERASE_TIME_US 40
`define COMMIT_TIME_US 20

`endif

/* verilog/flash_protection_pkg.sv */
// Types for the flash protection controller
package flash_protection_pkg;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_timing = 2'b01,
        st_apply = 2'b10
    } op_state_t;

    typedef enum logic [2:0] {
        op_none = 3'b000,
        op_program = 3'b001,
        op_erase = 3'b010,
        op_mass = 3'b011,
        op_commit = 3'b100
    } op_kind_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage : flash_protection_pkg

/* verilog/flash_protection_ctrl.sv */
// Flash array, bit-band SRAM and protection controller behind APB
//
// Functional notes
// - Alias address maps to one SRAM bit: byte offset*32 plus bit*4.
// - Erase sets every bit of the selected 1-KB block to one.
// - Program acts on one 32-bit word and only clears bits.
// - Each 2-KB granule has one program-enable and one read-enable bit.
// - Execute-only granule serves fetches only; data reads, changes blocked.
// - Program and erase timing counts cycles per microsecond from reload.
// - Program-enable one permits change; zero leaves granule unchanged.
// - Read-enable one allows data reads; zero allows only fetch.
// - Program-enable one, read-enable zero: change and execute, no reads.
// - Forbidden data read is refused with a bus fault.
// - Blocked program or erase sets access flag, interrupt when masked in.
// - All implemented protection bits start as one.
// - Bits only clear; uncommitted clears revert at power-on, committed stay.
// - Write to flash control with commit bit makes protection permanent.
// - Finished program or erase raises the programming-complete flag.
// - Raw status is always readable regardless of mask.
// - Writing one to masked clear register clears raw and masked status.
// - Debug field 0x2 enables debug access port, cleared blocks it.
// - Committed debug clear is permanent, effective from next power-up.
// - Debug lockout leaves the JTAG test access port working.
// - Commit address bit 0 selects program-enable (1) or read-enable (0).
// - Commit address 0x900 commits debug field and read-enable clears.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "flash_protection_cfg.svh"

module flash_protection_ctrl #(
    parameter int FLASH_WORDS = 256,
    parameter int WORDS_PER_BLOCK = 32,
    parameter int GRANULES = 4,
    parameter int SRAM_BYTES = 64,
    parameter int CLOCK_MHZ = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire flash_protection_pkg::apb_req_t apb_req,
    output flash_protection_pkg::apb_rsp_t apb_rsp,
    output logic flash_irq,
    output logic debug_port_enable,
    output logic tap_enable
);
    import flash_protection_pkg::*;

    localparam int AW = $clog2(FLASH_WORDS);
    localparam int GW = (GRANULES > 1) ? $clog2(GRANULES) : 1;
    localparam int SW = $clog2(SRAM_BYTES);
    localparam int GRAN_WORDS = 2 * WORDS_PER_BLOCK;

    initial begin
        if (FLASH_WORDS != GRANULES * GRAN_WORDS || GRANULES > 16 ||
            SRAM_BYTES < 4 || (SRAM_BYTES & (SRAM_BYTES - 1)) != 0 ||
            (WORDS_PER_BLOCK & (WORDS_PER_BLOCK - 1)) != 0) begin
            $error("flash_protection_ctrl: unsupported geometry");
        end
    end

    // Committed protection lives across presetn and por_n alike
    typedef struct packed {
        logic [31:0] read_committed;
        logic [31:0] program_committed;
        logic debug_latched;
    } nv_t;

    typedef struct packed {
        logic [FLASH_WORDS-1:0][31:0] flash;
        logic [SRAM_BYTES-1:0][7:0] sram;
        logic [31:0] read_enable_bits;
        logic [31:0] program_enable_bits;
        logic [7:0] usec_reload;
        logic [31:0] flash_target_address;
        logic [31:0] write_data;
        logic [3:0] flash_control;
        logic [1:0] raw_irq_status;
        logic [1:0] irq_mask;
        logic [31:0] alias_addr;
        logic [31:0] fetch_addr;
        op_state_t state;
        op_kind_t kind;
        logic [7:0] usec_cnt;
        logic [7:0] us_left;
        apb_rsp_t rsp;
        logic irq;
    } state_t;

    state_t r, next_r;
    // Nonvolatile store: factory values at time zero, no reset reaches it
    nv_t nv = '{`READ_ENABLE_RESET, `PROGRAM_ENABLE_RESET, 1'b0};
    nv_t next_nv;

    function automatic logic [GW-1:0] granule_of(input logic [31:0] a);
        granule_of = GW'(a[31:2] / 30'(GRAN_WORDS));
    endfunction : granule_of

    function automatic logic [AW-1:0] word_of(input logic [31:0] a);
        word_of = a[AW+1:2];
    endfunction : word_of

    // Range check compares the whole word address with the array size to catch overruns
    function automatic logic in_flash(input logic [31:0] a);
        in_flash = (a[31:2] < 30'(FLASH_WORDS));
    endfunction : in_flash

    logic [GW-1:0] tgt_gran;
    logic tgt_ok;
    logic [31:0] a;
    logic [31:0] wd;
    logic wr_setup;
    logic [SW+4:0] alias_off;

    // Next-state logic: bus decode, operation sequencer, status
    always_comb begin
        next_r = r;
        next_nv = nv;
        a = apb_req.paddr;
        wd = apb_req.pwdata;
        wr_setup = 1'b0;
        tgt_gran = granule_of(r.flash_target_address);
        tgt_ok = in_flash(r.flash_target_address);
        alias_off = r.alias_addr[SW+6:2];
        next_r.rsp.pready = 1'b0;
        next_r.rsp.pslverr = 1'b0;
        next_r.rsp.prdata = 32'h0000_0000;

        // One wait state: answer one cycle after the access phase starts
        if (apb_req.psel && apb_req.penable && !r.rsp.pready) begin
            next_r.rsp.pready = 1'b1;
            wr_setup = apb_req.pwrite;
            unique case (a[11:0])
                `OFF_TARGET_ADDRESS:
                    next_r.rsp.prdata = r.flash_target_address;
                `OFF_WRITE_DATA: next_r.rsp.prdata = r.write_data;
                `OFF_FLASH_CONTROL:
                    next_r.rsp.prdata = {28'h0, r.flash_control};
                `OFF_RAW_IRQ_STATUS:
                    next_r.rsp.prdata = {30'h0, r.raw_irq_status};
                `OFF_IRQ_MASK: next_r.rsp.prdata = {30'h0, r.irq_mask};
                `OFF_MASKED_STATUS_CLEAR: next_r.rsp.prdata =
                    {30'h0, r.raw_irq_status & r.irq_mask};
                `OFF_READ_ENABLE_BITS:
                    next_r.rsp.prdata = r.read_enable_bits;
                `OFF_PROGRAM_ENABLE_BITS:
                    next_r.rsp.prdata = r.program_enable_bits;
                `OFF_USEC_RELOAD: next_r.rsp.prdata = {24'h0, r.usec_reload};
                `OFF_ALIAS_ADDR: next_r.rsp.prdata = r.alias_addr;
                `OFF_ALIAS_DATA: next_r.rsp.prdata =
                    {31'h0, r.sram[alias_off[SW+4:3]][alias_off[2:0]]};
                `OFF_FETCH_ADDR: next_r.rsp.prdata = r.fetch_addr;
                `OFF_DEBUG_STATUS:
                    next_r.rsp.prdata = {31'h0, nv.debug_latched};
                `OFF_FETCH_DATA: begin
                    // Fetches ignore read enable; busy flash stalls as fault
                    if (!in_flash(r.fetch_addr) || r.state != st_idle) begin
                        next_r.rsp.pslverr = 1'b1;
                    end else begin
                        next_r.rsp.prdata = r.flash[word_of(r.fetch_addr)];
                    end
                end
                default: begin
                    // Data read of flash, window mirrors address offset
                    if (a[11:0] >= 12'h400 && !apb_req.pwrite) begin
                        if (!r.read_enable_bits[granule_of(
                                {20'h0, a[11:0] - 12'h400})] ||
                            r.state != st_idle) begin
                            next_r.rsp.pslverr = 1'b1;
                        end else begin
                            next_r.rsp.prdata = r.flash[word_of(
                                {20'h0, a[11:0] - 12'h400})];
                        end
                    end else begin
                        next_r.rsp.pslverr = 1'b1;
                        wr_setup = 1'b0;
                    end
                end
            endcase
        end

        // Register writes; flash data window is read-only
        if (wr_setup) begin
            unique case (a[11:0])
                `OFF_TARGET_ADDRESS: next_r.flash_target_address = wd;
                `OFF_WRITE_DATA: next_r.write_data = wd;
                `OFF_FLASH_CONTROL: begin
                    if (wd[31:`CTL_KEY_LSB] == `CTL_KEY &&
                        r.state == st_idle) begin
                        next_r.flash_control = wd[3:0];
                        next_r.kind = wd[`CTL_COMMIT] ? op_commit :
                            wd[`CTL_MERASE] ? op_mass :
                            wd[`CTL_ERASE] ? op_erase :
                            wd[`CTL_WRITE] ? op_program : op_none;
                        if (wd[3:0] != 4'h0) begin
                            next_r.state = st_timing;
                            next_r.usec_cnt = r.usec_reload;
                            next_r.us_left = wd[`CTL_COMMIT] ?
                                8'(`COMMIT_TIME_US) : wd[`CTL_WRITE] ?
                                8'(`PROGRAM_TIME_US) : 8'(`ERASE_TIME_US);
                        end
                    end
                end
                `OFF_IRQ_MASK: next_r.irq_mask = wd[1:0];
                `OFF_MASKED_STATUS_CLEAR:
                    next_r.raw_irq_status = r.raw_irq_status & ~wd[1:0];
                `OFF_READ_ENABLE_BITS: // clear-only
                    next_r.read_enable_bits = r.read_enable_bits & wd;
                `OFF_PROGRAM_ENABLE_BITS:
                    next_r.program_enable_bits = r.program_enable_bits & wd;
                `OFF_USEC_RELOAD: next_r.usec_reload = wd[7:0];
                `OFF_ALIAS_ADDR: next_r.alias_addr = wd;
                `OFF_ALIAS_DATA: // Single-bit atomic write
                    next_r.sram[alias_off[SW+4:3]][alias_off[2:0]] = wd[0];
                `OFF_FETCH_ADDR: next_r.fetch_addr = wd;
                default: ;
            endcase
        end

        // Microsecond tick from reload count, then operation length
        unique case (r.state)
            st_idle: ;
            st_timing: begin
                if (r.usec_cnt == 8'h00) begin
                    next_r.usec_cnt = r.usec_reload;
                    if (r.us_left <= 8'h01) begin
                        next_r.state = st_apply;
                    end else begin
                        next_r.us_left = r.us_left - 8'h01;
                    end
                end else begin
                    next_r.usec_cnt = r.usec_cnt - 8'h01;
                end
            end
            st_apply: begin
                next_r.state = st_idle;
                next_r.flash_control = 4'h0;
                unique case (r.kind)
                    op_program, op_erase: begin
                        if (tgt_ok &&
                            r.program_enable_bits[tgt_gran]) begin
                            if (r.kind == op_program) begin
                                next_r.flash[word_of(r.flash_target_address)]
                                    = r.flash[word_of(r.flash_target_address)]
                                    & r.write_data;
                            end else begin
                                for (int i = 0; i < FLASH_WORDS; i++) begin
                                    if (i / WORDS_PER_BLOCK ==
                                        int'(word_of(r.flash_target_address))
                                        / WORDS_PER_BLOCK) begin
                                        next_r.flash[i] = 32'hFFFF_FFFF;
                                    end
                                end
                            end
                            next_r.raw_irq_status[`IRQ_PROGRAM] = 1'b1;
                        end else begin
                            next_r.raw_irq_status[`IRQ_ACCESS] = 1'b1;
                        end
                    end
                    op_mass: begin
                        // Protected granules survive a mass erase
                        for (int i = 0; i < FLASH_WORDS; i++) begin
                            if (r.program_enable_bits[i / GRAN_WORDS]) begin
                                next_r.flash[i] = 32'hFFFF_FFFF;
                            end
                        end
                        next_r.raw_irq_status[`IRQ_PROGRAM] = 1'b1;
                        if (r.program_enable_bits[GRANULES-1:0] !=
                            {GRANULES{1'b1}}) begin
                            next_r.raw_irq_status[`IRQ_ACCESS] = 1'b1;
                        end
                    end
                    op_commit: begin
                        if (r.flash_target_address == `COMMIT_DEBUG_ADDR) begin
                            next_nv.read_committed = nv.read_committed &
                                r.read_enable_bits;
                        end else if (r.flash_target_address[0]) begin
                            next_nv.program_committed = nv.program_committed &
                                r.program_enable_bits;
                        end else begin
                            next_nv.read_committed = nv.read_committed &
                                {2'b11, r.read_enable_bits[29:0]};
                        end
                    end
                    default: ;
                endcase
            end
            default: next_r.state = st_idle;
        endcase

        // Raw status set beats a same-cycle clear
        next_r.irq = |(next_r.raw_irq_status & r.irq_mask);
    end

    // Working state: presetn reloads working copies from committed values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.flash <= {FLASH_WORDS{32'hFFFF_FFFF}};
            r.read_enable_bits <= `READ_ENABLE_RESET;
            r.program_enable_bits <= `PROGRAM_ENABLE_RESET;
            r.usec_reload <= `USEC_RELOAD_RESET;
            r.state <= st_idle;
            r.kind <= op_none;
        end else if (r.state == st_idle && r.kind == op_none &&
                     r.flash_control == 4'h0 && !r.rsp.pready &&
                     r.read_enable_bits == `READ_ENABLE_RESET &&
                     r.program_enable_bits == `PROGRAM_ENABLE_RESET &&
                     (nv.read_committed != `READ_ENABLE_RESET ||
                      nv.program_committed != `PROGRAM_ENABLE_RESET)) begin
            // First cycle after presetn: pick up committed clears
            r <= next_r;
            r.read_enable_bits <= nv.read_committed;
            r.program_enable_bits <= nv.program_committed;
            r.kind <= op_commit;
        end else begin
            r <= next_r;
        end
    end

    // Committed bits survive power-on reset, so clears stay
    always_ff @(posedge pclk) begin
        nv.read_committed <= next_nv.read_committed;
        nv.program_committed <= next_nv.program_committed;
        // Sticky once the debug field was seen enabled
        nv.debug_latched <= nv.debug_latched |
            (nv.read_committed[31:`DBG_LSB] == `DBG_ENABLED);
    end

    // Debug port enable held from power-up; TAP on after por_n release, never gated by debug
    logic debug_q;
    logic tap_q;
    logic seen_q;
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            debug_q <= 1'b0;
            tap_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            tap_q <= 1'b1;
            seen_q <= 1'b1;
            if (!seen_q) begin
                debug_q <= (nv.read_committed[31:`DBG_LSB] ==
                    `DBG_ENABLED);
            end
        end
    end

    assign apb_rsp = r.rsp;
    assign flash_irq = r.irq;
    assign debug_port_enable = debug_q;
    assign tap_enable = tap_q;

endmodule : flash_protection_ctrl

/* tb/apb_master_model.sv */
// Bus master standing for the processor core and debug access port
`timescale 1ns/1ps

module apb_master_model (
    input wire logic pclk,
    output flash_protection_pkg::apb_req_t req,
    input wire flash_protection_pkg::apb_rsp_t rsp
);
    import flash_protection_pkg::*;

    // Bus idle from time zero so nothing is taken during reset
    initial req = '0;

    // One transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q,
            output logic e);
        req <= '{paddr: {20'h0, a}, psel: 1'b1, penable: 1'b0,
                 pwrite: w, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
            @(posedge pclk);
        while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Idle edge so the next setup is not in this time step
        @(posedge pclk);
    endtask : xfer
endmodule : apb_master_model

/* tb/flash_protection_ctrl_properties.sv */
// Port-level checker for the flash protection controller
`timescale 1ns/1ps
`include "flash_protection_cfg.svh"

module flash_protection_ctrl_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire flash_protection_pkg::apb_req_t apb_req,
    input wire flash_protection_pkg::apb_rsp_t apb_rsp,
    input wire logic flash_irq,
    input wire logic debug_port_enable,
    input wire logic tap_enable
);
    import flash_protection_pkg::*;
    logic acc;
    logic done;
    logic [1:0] mask_sh;
    logic [2:0] up_cnt;

    ////////////////////////////////////////////////////////////////////
    // Access phase still waiting, and completed transfer
    assign acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;

    // Shadow of the mask and cycles since reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_sh <= 2'h0;
            up_cnt <= 3'h0;
        end else begin
            if (done && apb_req.pwrite && !apb_rsp.pslverr &&
                apb_req.paddr[11:0] == `OFF_IRQ_MASK) begin
                mask_sh <= apb_req.pwdata[1:0];
            end
            if (up_cnt != 3'h4) begin
                up_cnt <= up_cnt + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ONE_WAIT: assert property (acc |=> apb_rsp.pready)
        else $error("pready not one cycle after access");
    AST_PREADY_PULSE: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    AST_PREADY_CAUSE: assert property (
        apb_rsp.pready |-> $past(acc))
        else $error("pready without an access");
    AST_ERR_WITH_READY: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr outside pready");
    AST_UNMAPPED: assert property (
        acc && apb_req.paddr[11:0] == 12'h018 |=> apb_rsp.pslverr)
        else $error("unmapped access not faulted");
    AST_MASK_OFF: assert property (mask_sh == 2'h0 &&
        $past(mask_sh) == 2'h0 && $past(mask_sh, 2) == 2'h0
        |-> !flash_irq)
        else $error("interrupt with all sources masked");
    AST_CLEAR: assert property (done && apb_req.pwrite &&
        apb_req.paddr[11:0] == `OFF_MASKED_STATUS_CLEAR &&
        apb_req.pwdata[1:0] == 2'h3 |-> ##[1:3] !flash_irq)
        else $error("interrupt not cleared");
    AST_TAP_ON: assert property (up_cnt >= 3'h2 |-> tap_enable)
        else $error("test access port disabled");
    AST_DEBUG_HELD: assert property (
        up_cnt == 3'h4 |-> $stable(debug_port_enable))
        else $error("debug enable changed while running");

    // Main scenarios reached
    cover property (done && apb_rsp.pslverr);
    cover property ($rose(flash_irq));
    cover property (up_cnt == 3'h4 && !debug_port_enable);
endmodule : flash_protection_ctrl_properties

bind flash_protection_ctrl flash_protection_ctrl_properties chk (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .flash_irq(flash_irq),
    .debug_port_enable(debug_port_enable), .tap_enable(tap_enable));

/* tb/flash_protection_ctrl_tb.sv */
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps
`include "flash_protection_cfg.svh"

module flash_protection_ctrl_tb;
    import flash_protection_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    logic flash_irq;
    logic debug_port_enable;
    logic tap_enable;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] q;
    logic e;
    time t0;
    int cyc;

    always #12.5 pclk = ~pclk;

    flash_protection_ctrl uut (.pclk(pclk), .presetn(presetn),
        .por_n(por_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .flash_irq(flash_irq), .debug_port_enable(debug_port_enable),
        .tap_enable(tap_enable));
    apb_master_model host (.pclk(pclk), .req(apb_req), .rsp(apb_rsp));

    ////////////////////////////////////////////////////////////////////
    // Compare tasks, one per kind of result
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %0t word got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic chk_flag(input logic g, input logic x);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %0t flag got %b exp %b", $time, g, x);
        end
    endtask : chk_flag

    // Register access; masked read data and fault flag compared
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
            input logic [31:0] x, input logic xe);
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(q & m, x);
        chk_flag(e, xe);
    endtask : rd

    // Flash operation, polled until control reads back zero
    task automatic op(input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] c);
        wr(`OFF_TARGET_ADDRESS, a);
        wr(`OFF_WRITE_DATA, d);
        t0 = $time;
        wr(`OFF_FLASH_CONTROL, {`CTL_KEY, 12'h000, c});
        do
            host.xfer(1'b0, `OFF_FLASH_CONTROL, 32'h0, q, e);
        while (q !== 32'h0);
        cyc = int'(($time - t0) / 25);
    endtask : op

    // Power-up: both resets together for two cycles
    task automatic pwr();
        presetn <= 1'b0;
        por_n <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : pwr

    task automatic wrap_up();
        $display("errors %0d n_compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////
    // Watchdog; full run needs roughly 11000 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        wrap_up();
    end

    initial begin
        @(posedge pclk);
        pwr();
        rd(`OFF_READ_ENABLE_BITS, 32'hC000_000F, 32'h8000_000F, 0);
        rd(`OFF_PROGRAM_ENABLE_BITS, 32'hF, 32'hF, 0);
        rd(`OFF_USEC_RELOAD, 32'hFF, `USEC_RELOAD_RESET, 0);
        chk_flag(debug_port_enable, 1'b1);
        rd(12'h400, '1, '1, 0);
        rd(12'h018, 32'h0, 32'h0, 1);
        // Bit-band: byte 5 bit 2 cleared, bit 3 set
        wr(`OFF_ALIAS_ADDR, 32'hA8);
        wr(`OFF_ALIAS_DATA, 32'h0);
        wr(`OFF_ALIAS_ADDR, 32'hAC);
        wr(`OFF_ALIAS_DATA, 32'h1);
        rd(`OFF_ALIAS_DATA, 32'h1, 32'h1, 0);
        wr(`OFF_ALIAS_ADDR, 32'hA8);
        rd(`OFF_ALIAS_DATA, 32'h1, 32'h0, 0);
        // Program twice: second value only clears bits
        wr(`OFF_USEC_RELOAD, 32'h27);
        wr(`OFF_IRQ_MASK, 32'h3);
        op(32'h0, 32'hA5A5_0F0F, 4'h1);
        chk_flag(cyc >= 800 && cyc <= 820, 1'b1);
        chk_flag(flash_irq, 1'b1);
        rd(`OFF_RAW_IRQ_STATUS, 32'h3, 32'h2, 0);
        op(32'h0, 32'hFFFF_00FF, 4'h1);
        rd(12'h400, '1, 32'hA5A5_000F, 0);
        op(32'h80, 32'h1234_5678, 4'h1);
        op(32'h0, 32'h0, 4'h2);
        rd(12'h400, '1, '1, 0);
        rd(12'h480, '1, 32'h1234_5678, 0);
        wr(`OFF_MASKED_STATUS_CLEAR, 32'h3);
        rd(`OFF_RAW_IRQ_STATUS, 32'h3, 32'h0, 0);
        chk_flag(flash_irq, 1'b0);
        // Only access source unmasked; granule 1 and 3 not writable
        wr(`OFF_IRQ_MASK, 32'h1);
        wr(`OFF_PROGRAM_ENABLE_BITS, 32'hFFFF_FFF5);
        op(32'h100, 32'h0, 4'h1);
        rd(`OFF_RAW_IRQ_STATUS, 32'h3, 32'h1, 0);
        rd(`OFF_MASKED_STATUS_CLEAR, 32'h3, 32'h1, 0);
        chk_flag(flash_irq, 1'b1);
        rd(12'h500, '1, '1, 0);
        wr(`OFF_MASKED_STATUS_CLEAR, 32'h3);
        op(32'h4, 32'h0, 4'h1);
        rd(`OFF_RAW_IRQ_STATUS, 32'h3, 32'h2, 0);
        rd(`OFF_MASKED_STATUS_CLEAR, 32'h3, 32'h0, 0);
        chk_flag(flash_irq, 1'b0);
        wr(`OFF_MASKED_STATUS_CLEAR, 32'h3);
        // Granule 2 write-only, granule 3 execute-only
        wr(`OFF_READ_ENABLE_BITS, 32'hBFFF_FFF3);
        op(32'h200, 32'h0000_00C3, 4'h1);
        rd(12'h600, 32'h0, 32'h0, 1);
        wr(`OFF_FETCH_ADDR, 32'h200);
        rd(`OFF_FETCH_DATA, '1, 32'hC3, 0);
        op(32'h300, 32'h0, 4'h1);
        rd(`OFF_RAW_IRQ_STATUS, 32'h1, 32'h1, 0);
        rd(12'h700, 32'h0, 32'h0, 1);
        wr(`OFF_FETCH_ADDR, 32'h300);
        rd(`OFF_FETCH_DATA, '1, '1, 0);
        // Commit program enables, then mass erase skips protected
        op(32'h1, 32'h0, 4'h8);
        wr(`OFF_MASKED_STATUS_CLEAR, 32'h3);
        op(32'h0, 32'h0, 4'h4);
        rd(`OFF_RAW_IRQ_STATUS, 32'h1, 32'h1, 0);
        rd(12'h480, '1, '1, 0);
        wr(`OFF_PROGRAM_ENABLE_BITS, 32'hFFFF_FFF1);
        // Debug lockout commit acts only after power-up
        wr(`OFF_READ_ENABLE_BITS, 32'h3FFF_FFF3);
        op(`COMMIT_DEBUG_ADDR, 32'h0, 4'h8);
        chk_flag(debug_port_enable, 1'b1);
        pwr();
        rd(`OFF_READ_ENABLE_BITS, 32'hC000_000F, 32'h3, 0);
        rd(`OFF_PROGRAM_ENABLE_BITS, 32'hF, 32'h5, 0);
        chk_flag(debug_port_enable, 1'b0);
        chk_flag(tap_enable, 1'b1);
        wrap_up();
    end
endmodule : flash_protection_ctrl_tb
